//--- inc/pwt_pkg.sv
// pwt_pkg: constants shared by the pwm timer top and its channels.
// assumes a single 50 MHz clock and an 8-bit register port.
package pwt_pkg;

	// ----------------------------------------
	// sizes
	// ----------------------------------------
	localparam int PWT_NCH = 8; // channels
	localparam int PWT_RES = 8; // bits per lone channel
	localparam int PWT_CW = 16; // counter width of a joined pair

	// ----------------------------------------
	// register byte offsets
	// ----------------------------------------
	localparam logic [7:0] OFF_EN = 8'h00; // channel enables
	localparam logic [7:0] OFF_POL = 8'h04; // polarity
	localparam logic [7:0] OFF_CAE = 8'h08; // centre align
	localparam logic [7:0] OFF_CON = 8'h0C; // pair join
	localparam logic [7:0] OFF_PCM = 8'h10; // pcm mode
	localparam logic [7:0] OFF_CLK = 8'h14; // scaled clock select
	localparam logic [7:0] OFF_PRE = 8'h18; // prescalers a and b
	localparam logic [7:0] OFF_SCA = 8'h1C; // scaler for clock one
	localparam logic [7:0] OFF_SCB = 8'h20; // scaler for clock two
	localparam logic [7:0] OFF_PER = 8'h40; // period array base
	localparam logic [7:0] OFF_DTY = 8'h60; // duty array base
	localparam logic [7:0] OFF_CNT = 8'h80; // counter array base

	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int PRE_A_LSB = 0; // prescale a exponent
	localparam int PRE_B_LSB = 4; // prescale b exponent

	// ----------------------------------------
	// values after reset
	// ----------------------------------------
	localparam logic [7:0] RST_PER = 8'hFF;
	localparam logic [7:0] RST_DTY = 8'h00;
	localparam logic [7:0] RST_SCL = 8'h00;
	localparam logic [7:0] RST_CTL = 8'h00;
	localparam logic [2:0] RST_PRE = 3'h0;

	// ----------------------------------------
	// counter direction, one-hot
	// ----------------------------------------
	typedef enum logic [1:0] {
		PWT_UP = 2'b01,
		PWT_DOWN = 2'b10
	} pwt_dir_e;

endpackage

//--- hw/pwt_chan.sv
// pwt_chan: one modulation channel with buffered period and duty.
// assumes tick is a one-cycle enable from the top's clock dividers.
`timescale 1ns/1ps
module pwt_chan
	import pwt_pkg::*;
#(
	parameter int CW = PWT_CW
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// control
	input wire logic tick,
	input wire logic en,
	input wire logic pol,
	input wire logic center,
	input wire logic pcm,
	// buffered settings
	input wire logic [CW-1:0] per_in,
	input wire logic [CW-1:0] dty_in,
	// results
	output logic [CW-1:0] cnt_o,
	output logic out_o
);

	// ----------------------------------------
	// elaboration checks
	// ----------------------------------------
	// the counter needs room for a zero and a top value
	if (CW < 2) begin : g_bad
		$error("pwt_chan: CW must be at least 2");
	end

	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		logic [CW-1:0] cnt; // channel counter
		logic [CW-1:0] per; // active period
		logic [CW-1:0] dty; // active duty
		logic [CW-1:0] acc; // pcm accumulator
		pwt_dir_e dir; // centre direction
		logic hit; // pcm output level
		logic out; // pin level
	} pwt_chst_s;

	pwt_chst_s s_r;
	pwt_chst_s s_nxt;

	// next state: counting, loading, output level
	always_comb begin
		logic [CW:0] sum;
		logic [CW:0] sub;
		logic load;
		logic act;
		sum = {1'b0, s_r.acc} + {1'b0, s_r.dty};
		sub = sum - {1'b0, s_r.per};
		load = 1'b0;
		act = 1'b0;
		s_nxt = s_r;
		if (!en) begin
			// RL10 RL11 disabled loads buffers
			s_nxt.cnt = '0;
			s_nxt.acc = '0;
			s_nxt.dir = PWT_UP;
			s_nxt.hit = 1'b0;
			load = 1'b1;
		end else if (tick) begin
			// RL3 own counter steps
			if (s_r.per == '0) begin
				s_nxt.cnt = '0;
				load = 1'b1;
			end else if (center && !pcm) begin
				// RL14 up then down
				if (s_r.dir == PWT_UP) begin
					if (s_r.cnt >= s_r.per) begin
						s_nxt.dir = PWT_DOWN;
						s_nxt.cnt = s_r.cnt - 1'b1;
					end else begin
						s_nxt.cnt = s_r.cnt + 1'b1;
					end
				end else if (s_r.cnt <= 1) begin
					s_nxt.cnt = '0;
					s_nxt.dir = PWT_UP;
					load = 1'b1;
				end else begin
					s_nxt.cnt = s_r.cnt - 1'b1;
				end
			end else if (s_r.cnt >= s_r.per - 1'b1) begin
				// RL13 restart at period
				s_nxt.cnt = '0;
				load = 1'b1;
			end else begin
				s_nxt.cnt = s_r.cnt + 1'b1;
			end
			// RL5 pcm spreads transitions
			if (pcm) begin
				if (s_r.per == '0) begin
					s_nxt.hit = (s_r.dty != '0);
				end else if (sum >= {1'b0, s_r.per}) begin
					s_nxt.acc = sub[CW-1:0];
					s_nxt.hit = 1'b1;
				end else begin
					s_nxt.acc = sum[CW-1:0];
					s_nxt.hit = 1'b0;
				end
			end
		end
		// RL10 load at counter zero
		if (load) begin
			s_nxt.per = per_in;
			s_nxt.dty = dty_in;
		end
		// RL4 RL13 duty compare
		act = pcm ? s_nxt.hit : (s_nxt.cnt < s_nxt.dty);
		// RL6 polarity select
		s_nxt.out = en & (pol ? act : ~act);
	end

	// state register
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			s_r <= '{cnt: '0, per: '0, dty: '0, acc: '0,
				dir: PWT_UP, hit: 1'b0, out: 1'b0};
		end else begin
			s_r <= s_nxt;
		end
	end

	assign cnt_o = s_r.cnt;
	assign out_o = s_r.out;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	sequence s_cdown;
		en && tick && center && !pcm && s_r.dir == PWT_DOWN;
	endsequence
	sequence s_cturn;
		s_cdown ##0 (s_r.cnt == 1);
	endsequence

	property p_dis_idle;
		!en |=> out_o == 1'b0;
	endproperty
	a_dis_idle: assert property (p_dis_idle) // RL11
		else $error("disabled channel output not idle");

	property p_dis_load;
		!en |=> s_r.per == $past(per_in) && s_r.dty == $past(dty_in);
	endproperty
	a_dis_load: assert property (p_dis_load) // RL10
		else $error("disabled channel did not take buffers");

	property p_hold;
		en && $past(en) && s_r.cnt != '0 |-> $stable(s_r.per);
	endproperty
	a_hold: assert property (p_hold) // RL10
		else $error("period changed inside a period");

	property p_wrap;
		en && tick && !(center && !pcm) && s_r.per != '0 &&
			s_r.cnt == s_r.per - 1'b1 |=> s_r.cnt == '0;
	endproperty
	a_wrap: assert property (p_wrap) // RL13
		else $error("edge counter did not restart");

	property p_step;
		en && tick && !center && s_r.per != '0 &&
			s_r.cnt < s_r.per - 1'b1 |=> s_r.cnt == $past(s_r.cnt) + 1'b1;
	endproperty
	a_step: assert property (p_step) // RL3
		else $error("edge counter did not step by one");

	property p_no_tick;
		en && !tick |=> $stable(s_r.cnt);
	endproperty
	a_no_tick: assert property (p_no_tick) // RL12
		else $error("counter moved without its clock");

	property p_top;
		en && tick && center && !pcm && s_r.dir == PWT_UP &&
			s_r.per != '0 && s_r.cnt == s_r.per
			|=> s_r.dir == PWT_DOWN && s_r.cnt == $past(s_r.per) - 1'b1;
	endproperty
	a_top: assert property (p_top) // RL14
		else $error("centre counter did not turn at period");

	property p_turn;
		s_cturn |=> s_r.cnt == '0 ##1 s_r.dir == PWT_UP;
	endproperty
	a_turn: assert property (p_turn) // RL14
		else $error("centre counter did not turn at zero");

	property p_level;
		$past(en) && !$past(pcm) |->
			out_o == ($past(pol) ~^ (s_r.cnt < s_r.dty));
	endproperty
	a_level: assert property (p_level) // RL6
		else $error("output level does not match compare");

	property p_pcm_full;
		en && pcm && tick && s_r.per != '0 && s_r.dty >= s_r.per
			|=> out_o == $past(pol);
	endproperty
	a_pcm_full: assert property (p_pcm_full) // RL5
		else $error("pcm full duty not continuously active");

endmodule

//--- hw/pwt_top.sv
// pwt_top: eight channel pwm timer with register port and pins.
// assumes a master that strobes one cycle and never waits.
//
// How it works
// RL1 - eight channels, eight-bit period and duty
// RL2 - each channel holds period and duty
// RL3 - each channel counts on its own counter
// RL4 - duty settable from zero to full
// RL5 - pcm mode spreads output transitions
// RL6 - per channel polarity select
// RL7 - per channel edge or centre alignment
// RL8 - adjacent pairs join into sixteen bits
// RL9 - any mix of joined pairs works
// RL10 - writes buffered until counter zero or disable
// RL11 - each channel enabled on its own
// RL12 - four clock sources, two prescaled, two scaled
// RL13 - edge mode counts up, restarts, compares
// RL14 - centre mode counts up and down
`timescale 1ns/1ps
module pwt_top
	import pwt_pkg::*;
#(
	parameter int NCH = PWT_NCH
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// register port
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [7:0] rdata,
	// output pins
	output logic [NCH-1:0] pwm_o
);

	// ----------------------------------------
	// elaboration checks
	// ----------------------------------------
	// channels come in pairs and the arrays fit one 32-byte block
	if (NCH % 2 != 0 || NCH < 2 || NCH > PWT_NCH) begin : g_bad
		$error("pwt_top: NCH must be even, 2 to 8");
	end

	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		logic [NCH-1:0] en; // channel enable
		logic [NCH-1:0] pol; // polarity
		logic [NCH-1:0] cae; // centre align
		logic [NCH-1:0] pcm; // pcm mode
		logic [NCH-1:0] clks; // use scaled clock
		logic [NCH/2-1:0] con; // pair joined
		logic [2:0] pra; // prescale a exponent
		logic [2:0] prb; // prescale b exponent
		logic [7:0] sca; // scaler one divisor
		logic [7:0] scb; // scaler two divisor
		logic [NCH-1:0][PWT_RES-1:0] per; // period buffers
		logic [NCH-1:0][PWT_RES-1:0] dty; // duty buffers
		logic [6:0] pre; // shared prescale counter
		logic [7:0] sac; // scaler one counter
		logic [7:0] sbc; // scaler two counter
		logic ta; // clock a enable
		logic tb; // clock b enable
		logic tsa; // scaled clock one enable
		logic tsb; // scaled clock two enable
		logic [7:0] rdata; // read data
	} pwt_top_s;

	pwt_top_s s_r;
	pwt_top_s s_nxt;

	// channel counters and their byte view for readback
	logic [NCH-1:0][PWT_CW-1:0] ccnt;
	logic [NCH-1:0][7:0] cview;
	// per channel clock ticks after source select
	logic [NCH-1:0] ctick;

	// ----------------------------------------
	// decode helpers
	// ----------------------------------------
	// low bits that must all be set for a prescaled tick
	function automatic logic [6:0] pre_mask(input logic [2:0] e);
		logic [6:0] m;
		m = 7'h00;
		for (int k = 0; k < 7; k++) begin
			if (k < e) begin
				m[k] = 1'b1;
			end
		end
		return m;
	endfunction

	// address hits a word of a per channel array
	function automatic logic in_arr(input logic [7:0] a,
		input logic [7:0] base);
		return (a[7:5] == base[7:5]) && (a[1:0] == 2'h0) &&
			(32'(a[4:2]) < NCH);
	endfunction

	// ----------------------------------------
	// next state
	// ----------------------------------------
	// register writes, reads and the clock dividers
	always_comb begin
		logic [2:0] ix;
		logic [6:0] ma;
		logic [6:0] mb;
		ix = addr[4:2];
		ma = pre_mask(s_r.pra);
		mb = pre_mask(s_r.prb);
		s_nxt = s_r;

		// RL12 prescaled clocks a and b
		s_nxt.pre = s_r.pre + 7'h01;
		s_nxt.ta = ((s_r.pre & ma) == ma);
		s_nxt.tb = ((s_r.pre & mb) == mb);

		// RL12 scaled clocks from a and b
		s_nxt.tsa = 1'b0;
		if (s_r.ta) begin
			// at or past the divisor wraps at once, so a new
			// divisor never waits out a full 256-step lap
			if (s_r.sac >= s_r.sca - 8'h01) begin
				s_nxt.sac = 8'h00;
				s_nxt.tsa = 1'b1;
			end else begin
				s_nxt.sac = s_r.sac + 8'h01;
			end
		end
		s_nxt.tsb = 1'b0;
		if (s_r.tb) begin
			if (s_r.sbc >= s_r.scb - 8'h01) begin
				s_nxt.sbc = 8'h00;
				s_nxt.tsb = 1'b1;
			end else begin
				s_nxt.sbc = s_r.sbc + 8'h01;
			end
		end

		// register writes
		if (wr) begin
			case (addr)
				// RL11 channel enables
				OFF_EN: s_nxt.en = wdata[NCH-1:0];
				// RL6 polarity bits
				OFF_POL: s_nxt.pol = wdata[NCH-1:0];
				// RL7 alignment bits
				OFF_CAE: s_nxt.cae = wdata[NCH-1:0];
				// RL8 RL9 pair join bits
				OFF_CON: s_nxt.con = wdata[NCH/2-1:0];
				OFF_PCM: s_nxt.pcm = wdata[NCH-1:0];
				OFF_CLK: s_nxt.clks = wdata[NCH-1:0];
				OFF_PRE: begin
					s_nxt.pra = wdata[PRE_A_LSB +: 3];
					s_nxt.prb = wdata[PRE_B_LSB +: 3];
				end
				OFF_SCA: s_nxt.sca = wdata;
				OFF_SCB: s_nxt.scb = wdata;
				default: begin
					// RL2 RL10 period and duty buffers
					if (in_arr(addr, OFF_PER)) begin
						s_nxt.per[ix] = wdata;
					end else if (in_arr(addr, OFF_DTY)) begin
						s_nxt.dty[ix] = wdata;
					end
				end
			endcase
		end

		// read data stands one cycle only
		s_nxt.rdata = 8'h00;
		if (rd) begin
			case (addr)
				OFF_EN: s_nxt.rdata = 8'(s_r.en);
				OFF_POL: s_nxt.rdata = 8'(s_r.pol);
				OFF_CAE: s_nxt.rdata = 8'(s_r.cae);
				OFF_CON: s_nxt.rdata = 8'(s_r.con);
				OFF_PCM: s_nxt.rdata = 8'(s_r.pcm);
				OFF_CLK: s_nxt.rdata = 8'(s_r.clks);
				OFF_PRE: begin
					s_nxt.rdata[PRE_A_LSB +: 3] = s_r.pra;
					s_nxt.rdata[PRE_B_LSB +: 3] = s_r.prb;
				end
				OFF_SCA: s_nxt.rdata = s_r.sca;
				OFF_SCB: s_nxt.rdata = s_r.scb;
				default: begin
					// unmapped addresses read zero
					if (in_arr(addr, OFF_PER)) begin
						s_nxt.rdata = s_r.per[ix];
					end else if (in_arr(addr, OFF_DTY)) begin
						s_nxt.rdata = s_r.dty[ix];
					end else if (in_arr(addr, OFF_CNT)) begin
						s_nxt.rdata = cview[ix];
					end
				end
			endcase
		end
	end

	// state register
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			s_r.en <= '0;
			s_r.pol <= '0;
			s_r.cae <= '0;
			s_r.pcm <= '0;
			s_r.clks <= '0;
			s_r.con <= '0;
			s_r.pra <= RST_PRE;
			s_r.prb <= RST_PRE;
			s_r.sca <= RST_SCL;
			s_r.scb <= RST_SCL;
			s_r.per <= {NCH{RST_PER}};
			s_r.dty <= {NCH{RST_DTY}};
			s_r.pre <= 7'h00;
			s_r.sac <= 8'h00;
			s_r.sbc <= 8'h00;
			s_r.ta <= 1'b0;
			s_r.tb <= 1'b0;
			s_r.tsa <= 1'b0;
			s_r.tsb <= 1'b0;
			s_r.rdata <= RST_CTL;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign rdata = s_r.rdata;

	// ----------------------------------------
	// channels
	// ----------------------------------------
	for (genvar i = 0; i < NCH; i++) begin : g_ch
		logic cen;
		logic [PWT_CW-1:0] cper;
		logic [PWT_CW-1:0] cdty;

		// channels 0,1,4,5 sit on clock a, the others on clock b
		if ((i / 2) % 2 == 0) begin : g_a
			// RL12 pick clock a or scaled one
			assign ctick[i] = s_r.clks[i] ? s_r.tsa : s_r.ta;
		end else begin : g_b
			// RL12 pick clock b or scaled two
			assign ctick[i] = s_r.clks[i] ? s_r.tsb : s_r.tb;
		end

		if (i % 2 == 1) begin : g_odd
			// RL8 RL9 odd channel carries a joined pair
			assign cen = s_r.en[i];
			assign cper = s_r.con[i/2] ? {s_r.per[i], s_r.per[i-1]}
				: {8'h00, s_r.per[i]};
			assign cdty = s_r.con[i/2] ? {s_r.dty[i], s_r.dty[i-1]}
				: {8'h00, s_r.dty[i]};
			// joined counter shows its high byte here
			assign cview[i] = s_r.con[i/2] ? ccnt[i][15:8]
				: ccnt[i][7:0];
		end else begin : g_even
			// RL8 even channel idles while joined
			assign cen = s_r.en[i] & ~s_r.con[i/2];
			// RL1 lone channel is eight bits wide
			assign cper = {8'h00, s_r.per[i]};
			assign cdty = {8'h00, s_r.dty[i]};
			// joined counter shows its low byte here
			assign cview[i] = s_r.con[i/2] ? ccnt[i+1][7:0]
				: ccnt[i][7:0];
		end

		pwt_chan #(
			.CW(PWT_CW)
		) u_chan (
			.clk(clk),
			.rst_b(rst_b),
			.tick(ctick[i]),
			.en(cen),
			.pol(s_r.pol[i]),
			.center(s_r.cae[i]),
			.pcm(s_r.pcm[i]),
			.per_in(cper),
			.dty_in(cdty),
			.cnt_o(ccnt[i]),
			.out_o(pwm_o[i])
		);
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	property p_join;
		s_r.con[0] |=> pwm_o[0] == 1'b0;
	endproperty
	a_join: assert property (p_join) // RL8
		else $error("joined low channel still drives");

	property p_rd_en;
		rd && addr == OFF_EN |=> rdata == 8'($past(s_r.en));
	endproperty
	a_rd_en: assert property (p_rd_en) // RL11
		else $error("enable readback wrong");

	property p_scaled;
		s_r.tsa |-> $past(s_r.ta);
	endproperty
	a_scaled: assert property (p_scaled) // RL12
		else $error("scaled clock one without clock a");

	property p_rd_once;
		!$past(rd) |-> rdata == 8'h00;
	endproperty
	a_rd_once: assert property (p_rd_once) // RL2
		else $error("read data outside its cycle");

endmodule

//--- tb/pwt_load.sv
// pwt_load: loads on the pwm pins, counting active samples and edges.
// assumes the bench pulses clr for one cycle to open a window.
`timescale 1ns/1ps
module pwt_load
	import pwt_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// window control
	input wire logic clr,
	// pins seen by the loads
	input wire logic [PWT_NCH-1:0] pin,
	// results
	output logic [PWT_NCH-1:0][15:0] hi_cnt,
	output logic [PWT_NCH-1:0][15:0] edg_cnt
);
	logic [PWT_NCH-1:0] pin_q; // last sampled pin levels

	// per pin high-time and transition counters
	always_ff @(posedge clk) begin
		pin_q <= pin;
		for (int i = 0; i < PWT_NCH; i++) begin
			if (!rst_b || clr) begin
				hi_cnt[i] <= 16'h0000;
				edg_cnt[i] <= 16'h0000;
			end else begin
				hi_cnt[i] <= hi_cnt[i] + {15'h0000, pin[i]};
				edg_cnt[i] <= edg_cnt[i] + {15'h0000, pin[i] ^ pin_q[i]};
			end
		end
	end
endmodule

//--- tb/testbench.sv
// testbench: drives the pwm timer register port and scores its pins.
// assumes one 50 MHz clock and a prescale of one after reset.
`timescale 1ns/1ps
module testbench;
	import pwt_pkg::*;
	// --------------------------------
	// signals
	// --------------------------------
	logic clk, rst_b, wr, rd, clr; // clock, reset, strobes, window
	logic [7:0] addr, wdata, rdata, pwm_o, rv, mx; // port and scratch
	logic [PWT_NCH-1:0][15:0] hi_cnt; // active samples per pin
	logic [PWT_NCH-1:0][15:0] edg_cnt; // transitions per pin
	int n_errors, checked; // mismatch and comparison counts
	int per_a [8]; // chosen periods
	int d_a [8]; // chosen duties
	logic [7:0] en, pol, ctr, jn; // chosen control bytes
	int per_tab [8] = '{2, 3, 4, 5, 6, 8, 10, 12}; // divide 240 twice over

	pwt_top #(.NCH(PWT_NCH)) u_pwt_top (.clk(clk), .rst_b(rst_b),
		.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.pwm_o(pwm_o));
	pwt_load u_pwt_load (.clk(clk), .rst_b(rst_b), .clr(clr), .pin(pwm_o),
		.hi_cnt(hi_cnt), .edg_cnt(edg_cnt));

	// free running clock, 20 ns period
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// --------------------------------
	// tasks and expectations
	// --------------------------------
	// one comparison, reported at once on mismatch
	task automatic chk(input logic [15:0] got, input logic [15:0] exp,
		input string msg);
		checked++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED t=%0t %s got %h exp %h", $time, msg, got, exp);
		end
	endtask
	// single cycle write strobe
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	// single cycle read, data taken in the following cycle
	task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask
	// open a window of win samples on the loads
	task automatic measure(input int win);
		@(posedge clk);
		clr <= 1'b1;
		@(posedge clk);
		clr <= 1'b0;
		repeat (win) @(posedge clk);
		#1;
	endtask
	// set one lone channel and enable only it
	task automatic one_chan(input int ch, input int p, input int d,
		input logic pl, input logic c);
		wr_reg(OFF_EN, 8'h00);
		wr_reg(OFF_PER + 8'(4 * ch), 8'(p));
		wr_reg(OFF_DTY + 8'(4 * ch), 8'(d));
		wr_reg(OFF_POL, 8'(pl) << ch);
		wr_reg(OFF_CAE, 8'(c) << ch);
		wr_reg(OFF_EN, 8'h01 << ch);
		repeat (40) @(posedge clk);
	endtask
	// active samples over a window that spans whole periods
	function automatic logic [15:0] exp_hi(input int p, input int d,
		input logic pl, input logic c, input int win);
		int hi, len;
		hi = 0;
		len = c ? 2 * p : p;
		for (int k = 0; k <= p; k++) begin
			if (k < d && !c && k < p) hi++;
			if (k < d && c) hi += (k == 0 || k == p) ? 1 : 2;
		end
		hi = (win / len) * hi;
		return pl ? 16'(hi) : 16'(win - hi);
	endfunction

	// verdict and end of run
	task automatic give_verdict();
		$display("counts: %0d checks, %0d mismatches", checked, n_errors);
		if (n_errors == 0 && checked > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask

	// watchdog against a hung run
	initial begin
		repeat (40000) @(posedge clk);
		n_errors++;
		give_verdict();
	end

	// --------------------------------
	// main sequence
	// --------------------------------
	initial begin
		{rst_b, wr, rd, clr, addr, wdata} = '0;
		void'($urandom(70));
		repeat (10) @(posedge clk);
		rst_b <= 1'b1;
		// reset values, readback, unmapped place
		for (int i = 0; i < 8; i++) begin
			rd_reg(OFF_PER + 8'(4 * i), rv);
			chk({8'h00, rv}, {8'h00, RST_PER}, "period reset");
			rd_reg(OFF_DTY + 8'(4 * i), rv);
			chk({8'h00, rv}, {8'h00, RST_DTY}, "duty reset");
		end
		wr_reg(OFF_EN, 8'hA5);
		rd_reg(OFF_EN, rv);
		chk({8'h00, rv}, 16'h00A5, "enable readback");
		wr_reg(8'h3C, 8'h5A);
		rd_reg(8'h3C, rv);
		chk({8'h00, rv}, 16'h0000, "unmapped read");
		$display("test reset done");
		// edge, centre, polarity and duty extremes on channel 0
		for (int k = 0; k < 6; k++) begin
			int p, d;
			logic pl, c;
			p = (k == 3) ? 5 : (k == 5 ? 6 : 4);
			d = (k == 1) ? 0 : (k == 2 ? p : (k == 5 ? 6 : 2));
			pl = (k != 3 && k != 5);
			c = (k >= 4);
			one_chan(0, p, d, pl, c);
			measure(120);
			chk(hi_cnt[0], exp_hi(p, d, pl, c, 120), "wave shape");
		end
		$display("test shapes done");
		// random mixes of joins, enables, polarity and alignment
		for (int r = 0; r < 6; r++) begin
			wr_reg(OFF_EN, 8'h00);
			{jn, en, pol, ctr} = {4'h0, 4'($urandom), 24'($urandom)};
			for (int i = 0; i < 8; i++) begin
				per_a[i] = per_tab[$urandom % 8];
				d_a[i] = $urandom % (per_a[i] + 1);
				if (jn[i / 2] && i[0]) begin
					wr_reg(OFF_PER + 8'(4 * i - 4), 8'(per_a[i]));
					wr_reg(OFF_DTY + 8'(4 * i - 4), 8'(d_a[i]));
				end
				if (!(jn[i / 2] && !i[0])) begin
					wr_reg(OFF_PER + 8'(4 * i), jn[i / 2] ? 8'h00 : 8'(per_a[i]));
					wr_reg(OFF_DTY + 8'(4 * i), jn[i / 2] ? 8'h00 : 8'(d_a[i]));
				end
			end
			wr_reg(OFF_CON, jn);
			wr_reg(OFF_POL, pol);
			wr_reg(OFF_CAE, ctr);
			wr_reg(OFF_EN, en);
			repeat (60) @(posedge clk);
			measure(240);
			for (int i = 0; i < 8; i++) begin
				if (!en[i] || (jn[i / 2] && !i[0]))
					chk(hi_cnt[i], 16'h0000, "idle pin");
				else
					chk(hi_cnt[i], exp_hi(per_a[i], d_a[i], pol[i], ctr[i], 240),
						"channel mix");
			end
		end
		wr_reg(OFF_CON, 8'h00);
		wr_reg(OFF_CAE, 8'h00);
		$display("test random mix done");
		// pcm spreads three pulses over eight ticks
		wr_reg(OFF_PCM, 8'h08);
		one_chan(3, 8, 3, 1'b1, 1'b0);
		measure(120);
		chk(hi_cnt[3], 16'd45, "pcm duty");
		chk({15'h0000, edg_cnt[3] > 16'd30}, 16'h0001, "pcm spread");
		wr_reg(OFF_PCM, 8'h00);
		$display("test pcm done");
		// period change while running waits for the counter wrap;
		// clock b at half rate so every counter value is read once
		wr_reg(OFF_PRE, 8'h10);
		one_chan(2, 8, 4, 1'b1, 1'b0);
		// line up on a known count before writing the new period
		rv = 8'hFF;
		for (int i = 0; i < 20 && rv != 8'h01; i++) begin
			rd_reg(OFF_CNT + 8'h08, rv);
		end
		chk({8'h00, rv}, 16'h0001, "counter sync");
		wr_reg(OFF_PER + 8'h08, 8'h03);
		mx = 8'h00;
		for (int i = 0; i < 10; i++) begin
			rd_reg(OFF_CNT + 8'h08, rv);
			if (rv > mx) mx = rv;
		end
		chk({8'h00, mx}, 16'h0007, "old period kept");
		mx = 8'h00;
		for (int i = 0; i < 10; i++) begin
			rd_reg(OFF_CNT + 8'h08, rv);
			if (rv > mx) mx = rv;
		end
		chk({8'h00, mx}, 16'h0002, "new period taken");
		$display("test buffering done");
		// joined pair 1:0 with a period above eight bits
		wr_reg(OFF_EN, 8'h00);
		wr_reg(OFF_CON, 8'h01);
		wr_reg(OFF_PER + 8'h04, 8'h01);
		wr_reg(OFF_PER, 8'h00);
		wr_reg(OFF_DTY + 8'h04, 8'h00);
		wr_reg(OFF_DTY, 8'h40);
		wr_reg(OFF_POL, 8'h02);
		wr_reg(OFF_EN, 8'h02);
		repeat (20) @(posedge clk);
		measure(256);
		chk(hi_cnt[1], exp_hi(256, 64, 1'b1, 1'b0, 256), "wide duty");
		chk(hi_cnt[0], 16'h0000, "wide low pin idle");
		wr_reg(OFF_CON, 8'h00);
		$display("test wide pair done");
		// scaled clock sources on both halves of the block
		wr_reg(OFF_PRE, 8'h21);
		wr_reg(OFF_SCA, 8'h02);
		wr_reg(OFF_SCB, 8'h01);
		wr_reg(OFF_CLK, 8'h05);
		one_chan(2, 4, 1, 1'b1, 1'b0);
		wr_reg(OFF_PER, 8'h04);
		wr_reg(OFF_DTY, 8'h01);
		wr_reg(OFF_POL, 8'h05);
		wr_reg(OFF_EN, 8'h05);
		repeat (64) @(posedge clk);
		measure(128);
		chk(hi_cnt[0], 16'd32, "scaled clock one");
		chk(hi_cnt[2], 16'd32, "scaled clock two");
		chk(edg_cnt[0], 16'd16, "scaled one rate");
		chk(edg_cnt[2], 16'd16, "scaled two rate");
		$display("test clocks done");
		give_verdict();
	end
endmodule
